/* quad_rate_sram_port_logic.sv */
// Pin level logic of a separate-port, two-word burst, double data rate SRAM.
`include "sram_port_defs.svh"

// What this block does
// R1: Write data is captured on both edges of the main clock pair.
// R2: Write port select low on a main clock rising edge starts a write.
// R3: Write port select high deselects the write port; write data ignored.
// R4: Active-low lane masks are sampled with each write beat on both phases.
// R5: Bytes whose lane mask is high stay unchanged in the array.
// R6: Read address taken on main rising edge, write address on complement edge.
// R7: Array has two halves per location; 19 or 18 address bits.
// R8: Address is ignored on edges of a deselected port.
// R9: Read data launches on rising edges of the output clock pair.
// R10: In single clock mode read data launches on the main clock pair.
// R11: Read data outputs float while the read port is deselected and no read is in flight.
// R12: Read port select low on a main clock rising edge starts a read; outside single clock mode, only once the previous read is acknowledged.
// R13: Reads in flight finish, then outputs float after the next rising edge.
// R14: Every read is a two-word burst from one location.
// R15: Every access begins on a rising edge of the main input clock.
// R16: In single clock mode, PLL disable low gives the shorter one-cycle read latency mode.
// R17: Echo strobe runs free, from the output clock or main clock.
// R18: First write word with masks on main edge, second on complement edge.
module quad_rate_sram_port_logic
#(
	parameter int DATA_W = `SRAM_NARROW_DATA_W,
	parameter int ADDR_W = `SRAM_NARROW_ADDR_W
)
(
	input  wire logic                          I_MCLK,
	input  wire logic                          I_SYS_RST,
	input  wire logic                          I_OCLK,
	input  wire logic                          I_SINGLE_CLOCK,
	input  wire logic                          I_PLL_DISABLE_N,
	input  wire logic                          I_WRITE_PORT_SELECT_N,
	input  wire logic                          I_READ_PORT_SELECT_N,
	input  wire logic [ADDR_W-1:0]             I_ADDR,
	input  wire logic [DATA_W-1:0]             I_WDATA,
	input  wire logic [DATA_W/`SRAM_LANE_W-1:0] I_BYTE_LANE_MASK_N,
	output logic      [DATA_W-1:0]             O_RDATA,
	output logic                               O_RDATA_OE,
	output logic                               O_ECHO_STROBE,
	output logic                               O_ECHO_STROBE_N,
	output sram_port_pkg::pair_phase_type      O_PAIR_PHASE
);
	import sram_port_pkg::*;

	localparam int LANES = DATA_W / `SRAM_LANE_W;
	localparam int LW = `SRAM_LANE_W;
	localparam int DEPTH = 1 << ADDR_W;
	localparam int PD = `SRAM_PIPE_DEPTH;

	typedef struct packed
	{
		pair_phase_type               phase;
		logic                         single_mode;
		logic                         pll_off;
		logic                         wr_pending;
		logic [DATA_W-1:0]            wr_beat0;
		logic [LANES-1:0]             wr_mask0;
		logic [PD-1:0]                pv;
		logic [PD-1:0][2*DATA_W-1:0]  pd;
		logic [DATA_W-1:0]            kq;
		logic                         koe;
		logic                         kecho;
		logic                         req;
		logic [2*DATA_W-1:0]          xfer;
	} core_state_type;

	core_state_type                s;
	core_state_type                next_s;
	logic [`SRAM_STRAP_W-1:0]      strap_pins;
	logic [`SRAM_STRAP_W-1:0]      strap_sync;
	logic                          ack_sync;
	logic                          launch_ack;
	logic                          oclk_rst;
	logic [DATA_W-1:0]             c_q;
	logic                          c_oe;
	logic                          c_echo;
	logic                          rd_start;
	logic                          wr_start;
	logic                          wr_commit;
	logic [DATA_W-1:0]             rd_even;
	logic [DATA_W-1:0]             rd_odd;
	logic [2*DATA_W-1:0]           rd_pair;
	logic [1:0]                    w0_idx;
	logic [1:0]                    w1_idx;

	assign strap_pins[`SRAM_STRAP_SINGLE] = I_SINGLE_CLOCK;
	assign strap_pins[`SRAM_STRAP_PLL_N] = I_PLL_DISABLE_N;

	sync_level #(.WIDTH(`SRAM_STRAP_W)) u_strap_sync
	(
		.i_clk   (I_MCLK),
		.i_async (strap_pins),
		.o_sync  (strap_sync)
	);

	sync_level #(.WIDTH(1)) u_ack_sync
	(
		.i_clk   (I_MCLK),
		.i_async (launch_ack),
		.o_sync  (ack_sync)
	);

	sync_level #(.WIDTH(1)) u_oclk_rst_sync
	(
		.i_clk   (I_OCLK),
		.i_async (I_SYS_RST),
		.o_sync  (oclk_rst)
	);

	logic req_oclk;

	sync_level #(.WIDTH(1)) u_req_sync
	(
		.i_clk   (I_OCLK),
		.i_async (s.req),
		.o_sync  (req_oclk)
	);

	read_launch #(.DATA_W(DATA_W)) u_read_launch
	(
		.i_oclk (I_OCLK),
		.i_rst  (oclk_rst),
		.i_req  (req_oclk),
		.i_pair (s.xfer),
		.o_ack  (launch_ack),
		.o_q    (c_q),
		.o_oe   (c_oe),
		.o_echo (c_echo)
	);

	// Accesses start only on the true edge of the main pair.
	assign rd_start = (s.phase == PH_TRUE) && !I_READ_PORT_SELECT_N && !I_SYS_RST; // R12 R15
	assign wr_start = (s.phase == PH_TRUE) && !I_WRITE_PORT_SELECT_N && !I_SYS_RST; // R2 R15
	// The write address is taken on the complement edge, only for a selected port.
	assign wr_commit = (s.phase == PH_COMP) && s.wr_pending && !I_SYS_RST; // R6 R8

	// Each location holds two words, one per array half, split into byte lanes.
	for (genvar l = 0; l < LANES; l++)
	begin : g_lane
		logic [LW-1:0] mem_even [DEPTH];
		logic [LW-1:0] mem_odd [DEPTH];

		always_ff @(posedge I_MCLK)
		begin
			if (wr_commit && !s.wr_mask0[l]) // R4 R5
			begin
				mem_even[I_ADDR] <= s.wr_beat0[l*LW +: LW]; // R7
			end
			if (wr_commit && !I_BYTE_LANE_MASK_N[l]) // R4 R5
			begin
				mem_odd[I_ADDR] <= I_WDATA[l*LW +: LW]; // R1 R18
			end
		end

		assign rd_even[l*LW +: LW] = mem_even[I_ADDR]; // R6
		assign rd_odd[l*LW +: LW] = mem_odd[I_ADDR];
	end

	assign rd_pair = {rd_odd, rd_even}; // R14

	// PLL off shortens the read pipeline by one edge.
	assign w0_idx = s.pll_off ? 2'(`SRAM_LAT_PLL_OFF - 1) : 2'(`SRAM_LAT_PLL_ON - 1); // R16
	assign w1_idx = w0_idx + 2'h1;

	always_comb
	begin
		next_s = s;
		next_s.phase = (s.phase == PH_TRUE) ? PH_COMP : PH_TRUE;
		next_s.kecho = (s.phase == PH_TRUE); // R17

		if (s.phase == PH_TRUE)
		begin
			// A deselected write port drops any beat on the data pins.
			next_s.wr_pending = wr_start; // R3
			if (wr_start)
			begin
				next_s.wr_beat0 = I_WDATA; // R1 R18
				next_s.wr_mask0 = I_BYTE_LANE_MASK_N; // R4
			end
		end
		else
		begin
			next_s.wr_pending = 1'b0;
		end

		// Single clock read pipeline; entries age one edge per clock.
		next_s.pv = {s.pv[PD-2:0], rd_start};
		next_s.pd = {s.pd[PD-2:0], rd_pair};
		if (s.pv[w0_idx])
		begin
			next_s.kq = s.pd[w0_idx][DATA_W-1:0]; // R10 R14
			next_s.koe = 1'b1;
		end
		else if (s.pv[w1_idx])
		begin
			next_s.kq = s.pd[w1_idx][2*DATA_W-1:DATA_W]; // R10 R14
			next_s.koe = 1'b1;
		end
		else if (s.phase == PH_TRUE)
		begin
			next_s.koe = 1'b0; // R11 R13
		end

		// Hand-off to the output clock domain holds one burst at a time; a read
		// that arrives while the previous one is still unacknowledged is dropped.
		if (rd_start && !s.single_mode && (s.req == ack_sync))
		begin
			next_s.xfer = rd_pair; // R9
			next_s.req = ~s.req;
		end

		if (I_SYS_RST)
		begin
			next_s = '0;
			next_s.phase = PH_TRUE;
			// Both ends of the read hand-off restart from zero, so no unknown circles round.
			// Mode straps are caught while reset is held.
			next_s.single_mode = strap_sync[`SRAM_STRAP_SINGLE];
			next_s.pll_off = !strap_sync[`SRAM_STRAP_PLL_N]; // R16
		end
	end

	always_ff @(posedge I_MCLK)
	begin
		s <= next_s;
	end

	// The mode is fixed after reset, so this select never switches during traffic.
	assign O_RDATA = s.single_mode ? s.kq : c_q; // R10
	assign O_RDATA_OE = s.single_mode ? s.koe : c_oe; // R11
	assign O_ECHO_STROBE = s.single_mode ? s.kecho : c_echo; // R17
	assign O_ECHO_STROBE_N = s.single_mode ? !s.kecho : !c_echo;
	assign O_PAIR_PHASE = s.phase;

endmodule : quad_rate_sram_port_logic

/* sram_port_defs.svh */
// Constants for the burst SRAM port logic: widths, lane layout and pipeline timing.
`ifndef SRAM_PORT_DEFS_SVH
`define SRAM_PORT_DEFS_SVH

`define SRAM_NARROW_DATA_W   18
`define SRAM_NARROW_ADDR_W   19
`define SRAM_WIDE_DATA_W     36
`define SRAM_WIDE_ADDR_W     18
`define SRAM_LANE_W          9
`define SRAM_BURST_LEN       2
`define SRAM_PIPE_DEPTH      4
`define SRAM_LAT_PLL_ON      3
`define SRAM_LAT_PLL_OFF     2
`define SRAM_PLL_OFF_MAX_MHZ 167
`define SRAM_STRAP_SINGLE    0
`define SRAM_STRAP_PLL_N     1
`define SRAM_STRAP_W         2

`endif

/* sram_port_pkg.sv */
// Types shared by the burst SRAM port logic modules.
package sram_port_pkg;

	// Which edge of a clock pair the next rising edge of the edge clock is.
	typedef enum logic
	{
		PH_TRUE = 1'b0,
		PH_COMP = 1'b1
	} pair_phase_type;

	// Read launcher states in the output clock domain, Gray coded.
	typedef enum logic [1:0]
	{
		L_IDLE   = 2'b00,
		L_FIRST  = 2'b01,
		L_SECOND = 2'b11
	} launch_state_type;

endpackage : sram_port_pkg

/* sync_level.sv */
// Two flip-flop synchroniser for levels entering a clock domain.
`include "sram_port_defs.svh"

module sync_level
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             i_clk,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	import sram_port_pkg::*;

	typedef struct packed
	{
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] held;
	} sync_state_type;

	sync_state_type s;
	sync_state_type next_s;

	// No reset here, so that this stage can also carry the reset itself.
	always_comb
	begin
		next_s.meta = i_async;
		next_s.held = s.meta;
	end

	always_ff @(posedge i_clk)
	begin
		s <= next_s;
	end

	assign o_sync = s.held;

endmodule : sync_level

/* read_launch.sv */
// Output clock domain read launcher: two-word bursts, output enable and echo strobe.
`include "sram_port_defs.svh"

module read_launch
#(
	parameter int DATA_W = `SRAM_NARROW_DATA_W
)
(
	input  wire logic                i_oclk,
	input  wire logic                i_rst,
	input  wire logic                i_req,
	input  wire logic [2*DATA_W-1:0] i_pair,
	output logic                     o_ack,
	output logic      [DATA_W-1:0]   o_q,
	output logic                     o_oe,
	output logic                     o_echo
);
	import sram_port_pkg::*;

	typedef struct packed
	{
		pair_phase_type   phase;
		launch_state_type state;
		logic             seen;
		logic [DATA_W-1:0] second;
		logic [DATA_W-1:0] q;
		logic             oe;
		logic             echo;
	} launch_state_reg_type;

	launch_state_reg_type s;
	launch_state_reg_type next_s;
	logic                 pending;

	always_comb
	begin
		next_s = s;
		pending = (i_req != s.seen);
		next_s.phase = (s.phase == PH_TRUE) ? PH_COMP : PH_TRUE;
		// The echo strobe is free running and follows the output clock pair.
		next_s.echo = (s.phase == PH_TRUE); // R17
		case (s.state)
			L_IDLE:
			begin
				if (pending && (s.phase == PH_TRUE))
				begin
					next_s.q = i_pair[DATA_W-1:0]; // R9
					next_s.second = i_pair[2*DATA_W-1:DATA_W]; // R14
					next_s.seen = i_req;
					next_s.oe = 1'b1;
					next_s.state = L_FIRST;
				end
			end
			L_FIRST:
			begin
				next_s.q = s.second; // R14
				next_s.state = L_SECOND;
			end
			L_SECOND:
			begin
				if (pending)
				begin
					next_s.q = i_pair[DATA_W-1:0]; // R9
					next_s.second = i_pair[2*DATA_W-1:DATA_W];
					next_s.seen = i_req;
					next_s.state = L_FIRST;
				end
				else
				begin
					// The burst in flight is done; release the bus on this C edge.
					next_s.oe = 1'b0; // R13
					next_s.state = L_IDLE;
				end
			end
			default:
			begin
				next_s.oe = 1'b0;
				next_s.state = L_IDLE;
			end
		endcase
		if (i_rst)
		begin
			next_s = '0;
			next_s.phase = PH_TRUE;
			next_s.state = L_IDLE;
		end
	end

	always_ff @(posedge i_oclk)
	begin
		s <= next_s;
	end

	assign o_ack = s.seen;
	assign o_q = s.q;
	assign o_oe = s.oe;
	assign o_echo = s.echo;

endmodule : read_launch

/* sram_port_checker.sv */
// Concurrent checks on the pins of the burst SRAM port logic.
module sram_port_checker
(
	input wire logic                          I_MCLK,
	input wire logic                          I_SYS_RST,
	input wire logic                          I_OCLK,
	input wire logic                          I_SINGLE_CLOCK,
	input wire logic                          I_PLL_DISABLE_N,
	input wire logic                          I_READ_PORT_SELECT_N,
	input wire logic                          O_RDATA_OE,
	input wire logic                          O_ECHO_STROBE,
	input wire logic                          O_ECHO_STROBE_N,
	input wire logic                          O_PAIR_PHASE
);
	timeunit 1ns;
	timeprecision 100ps;
	wire s_off     = I_SINGLE_CLOCK && !I_PLL_DISABLE_N;
	wire s_on      = I_SINGLE_CLOCK && I_PLL_DISABLE_N;
	wire true_edge = O_PAIR_PHASE == sram_port_pkg::PH_TRUE;
	wire rd_req    = true_edge && !I_READ_PORT_SELECT_N;

	phase_start_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		$past(I_SYS_RST) |-> true_edge ##1 !true_edge) else $error("phase not true after reset");
	phase_alt_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		!$past(I_SYS_RST) |-> O_PAIR_PHASE != $past(O_PAIR_PHASE)) else $error("phase stuck");
	echo_pair_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		O_ECHO_STROBE_N == !O_ECHO_STROBE) else $error("echo pair not inverse");
	echo_single_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		I_SINGLE_CLOCK && !$past(I_SYS_RST) |-> O_ECHO_STROBE == O_PAIR_PHASE)
		else $error("echo not on main clock");
	rd_lat_off_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		s_off && rd_req |-> ##3 O_RDATA_OE ##1 O_RDATA_OE) else $error("short latency burst");
	rd_lat_on_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		s_on && rd_req |-> ##4 O_RDATA_OE ##1 O_RDATA_OE) else $error("long latency burst");
	oe_release_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		s_off && true_edge && I_READ_PORT_SELECT_N |-> ##3 !O_RDATA_OE)
		else $error("outputs driven while deselected");
	echo_oclk_a: assert property (@(posedge I_OCLK) disable iff (I_SYS_RST)
		!I_SINGLE_CLOCK && !$past(I_SYS_RST) && !$past(I_SYS_RST, 2) && !$past(I_SYS_RST, 3)
		|-> O_ECHO_STROBE != $past(O_ECHO_STROBE)) else $error("echo not free running");
	burst_oclk_a: assert property (@(posedge I_OCLK) disable iff (I_SYS_RST)
		!I_SINGLE_CLOCK && $rose(O_RDATA_OE) |=> O_RDATA_OE ##1 !O_RDATA_OE)
		else $error("output clock burst length");
endmodule : sram_port_checker

bind quad_rate_sram_port_logic sram_port_checker chk_u (.I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST),
	.I_OCLK(I_OCLK), .I_SINGLE_CLOCK(I_SINGLE_CLOCK), .I_PLL_DISABLE_N(I_PLL_DISABLE_N),
	.I_READ_PORT_SELECT_N(I_READ_PORT_SELECT_N), .O_RDATA_OE(O_RDATA_OE),
	.O_ECHO_STROBE(O_ECHO_STROBE), .O_ECHO_STROBE_N(O_ECHO_STROBE_N), .O_PAIR_PHASE(O_PAIR_PHASE));

/* ctl_model.sv */
// Memory controller model: drives port selects, shared address, write beats and lane masks.
module ctl_model
#(
	parameter int DATA_W = 18,
	parameter int ADDR_W = 4
)
(
	input  wire logic                  i_mclk,
	input  wire logic                  i_phase,
	output logic                       o_wsel_n,
	output logic                       o_rsel_n,
	output logic      [ADDR_W-1:0]     o_addr,
	output logic      [DATA_W-1:0]     o_wdata,
	output logic      [DATA_W/9-1:0]   o_mask_n
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		o_wsel_n = 1'b1;
		o_rsel_n = 1'b1;
		o_addr   = '0;
		o_wdata  = '0;
		o_mask_n = '1;
	end

	// Requests start only ahead of a true edge, so step past complement edges first.
	task automatic to_true();
		while (i_phase !== 1'b0)
			@(posedge i_mclk) #1;
	endtask : to_true

	// Released lines show the inverse of their last value so stale data never matches.
	task automatic release_bus();
		o_addr   = ~o_addr;
		o_wdata  = ~o_wdata;
		o_mask_n = ~o_mask_n;
	endtask : release_bus

	task automatic write(input logic sel_n, input logic [ADDR_W-1:0] a,
		input logic [2*DATA_W-1:0] w, input logic [2*(DATA_W/9)-1:0] m);
		to_true();
		o_wsel_n = sel_n;
		o_wdata  = w[DATA_W-1:0];
		o_mask_n = m[DATA_W/9-1:0];
		@(posedge i_mclk) #1;
		o_wsel_n = 1'b1;
		o_addr   = a;
		o_wdata  = w[2*DATA_W-1:DATA_W];
		o_mask_n = m[2*(DATA_W/9)-1:DATA_W/9];
		@(posedge i_mclk) #1;
		release_bus();
	endtask : write

	task automatic read(input logic [ADDR_W-1:0] a);
		to_true();
		o_rsel_n = 1'b0;
		o_addr   = a;
		@(posedge i_mclk) #1;
		o_rsel_n = 1'b1;
		release_bus();
	endtask : read
endmodule : ctl_model

/* quad_rate_sram_port_logic_test.sv */
// Self-checking bench for the burst SRAM port logic in all three clocking modes.
module quad_rate_sram_port_logic_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int DW = 18;
	localparam int AW = 4;
	logic                          mclk, oclk, rst, single, pll_n;
	logic                          wsel_n, rsel_n, oe, echo;
	logic [AW-1:0]                 addr;
	logic [DW-1:0]                 wdata, rdata;
	logic [1:0]                    mask_n;
	sram_port_pkg::pair_phase_type phase;
	int                            n_mismatch = 0;
	int                            compares = 0;

	quad_rate_sram_port_logic #(.DATA_W(DW), .ADDR_W(AW)) dut_u (.I_MCLK(mclk), .I_SYS_RST(rst),
		.I_OCLK(oclk), .I_SINGLE_CLOCK(single), .I_PLL_DISABLE_N(pll_n),
		.I_WRITE_PORT_SELECT_N(wsel_n), .I_READ_PORT_SELECT_N(rsel_n), .I_ADDR(addr),
		.I_WDATA(wdata), .I_BYTE_LANE_MASK_N(mask_n), .O_RDATA(rdata), .O_RDATA_OE(oe),
		.O_ECHO_STROBE(echo), .O_ECHO_STROBE_N(), .O_PAIR_PHASE(phase));
	ctl_model #(.DATA_W(DW), .ADDR_W(AW)) ctl_u (.i_mclk(mclk), .i_phase(phase),
		.o_wsel_n(wsel_n), .o_rsel_n(rsel_n), .o_addr(addr), .o_wdata(wdata), .o_mask_n(mask_n));

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial
	begin
		oclk = 1'b0;
		#3;
		forever #32 oclk = ~oclk;
	end

	task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run();
		$display("mismatches %0d, compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run

	// Later resets span several output clock edges so that domain is reset as well.
	task automatic do_reset(input logic s, input logic p, input int n);
		rst    = 1'b1;
		single = s;
		pll_n  = p;
		repeat (n) @(posedge mclk);
		#1;
		check(oe, 1'b0);
		check(phase, 1'b0);
		rst = 1'b0;
	endtask : do_reset

	task automatic read_back(input logic [AW-1:0] a, input logic [2*DW-1:0] w);
		ctl_u.read(a);
		if (single)
		begin
			repeat (pll_n ? 3 : 2) @(posedge mclk);
			#1 check(oe, 1'b1);
			check(rdata, w[DW-1:0]);
			@(posedge mclk) #1 check(rdata, w[2*DW-1:DW]);
			repeat (pll_n ? 2 : 1) @(posedge mclk);
			#1 check(oe, 1'b0);
		end
		else
		begin
			for (int i = 0; i < 8 && oe !== 1'b1; i++)
				@(posedge oclk) #1;
			check(oe, 1'b1);
			check(rdata, w[DW-1:0]);
			@(posedge oclk) #1 check(rdata, w[2*DW-1:DW]);
			@(posedge oclk) #1 check(oe, 1'b0);
		end
	endtask : read_back

	task automatic t_write_read();
		ctl_u.write(1'b0, 4'h0, 36'h123456789, 4'h0);
		ctl_u.write(1'b0, 4'hf, 36'h987654321, 4'h0);
		read_back(4'h0, 36'h123456789);
		read_back(4'hf, 36'h987654321);
	endtask : t_write_read

	task automatic t_mask_deselect();
		logic [35:0] o = 36'haaaaaaaaa;
		logic [35:0] n = 36'h555555555;
		ctl_u.write(1'b0, 4'h5, o, 4'h0);
		ctl_u.write(1'b0, 4'h5, n, 4'h6);
		ctl_u.write(1'b1, 4'h5, 36'h0, 4'h0);
		ctl_u.write(1'b1, 4'h0, 36'h0, 4'h0);
		read_back(4'h5, {n[35:27], o[26:18], o[17:9], n[8:0]});
		read_back(4'h0, 36'h123456789);
	endtask : t_mask_deselect

	initial
	begin
		for (int m = 0; m < 3; m++)
		begin
			do_reset(m != 2, m != 0, (m == 0) ? 3 : 30);
			t_write_read();
			t_mask_deselect();
		end
		complete_run();
	end

	initial
	begin
		#50us;
		n_mismatch++;
		complete_run();
	end
endmodule : quad_rate_sram_port_logic_test
